// ==== src/baud_pkg.sv ====
// constants, types and operation summary of the fractional baud generator
//
// Operation
// - modem control bit 7 selects a prescale of 1 (clear) or 4 (set) ahead of the divisor.
// - the prescaled clock is divided by 1 up to 65536 minus 1/16 in steps of 1/16.
// - the divided output is the channel sampling tick at 16x, 8x or 4x the bit rate.
// - after reset the divisor is one: low byte 0x01, high byte and fraction 0x00.
// - the integer divisor comes from the low and high bytes, the fraction from its own register.
// - only the four low fraction bits exist, giving 0 to 15/16.
// - both selection fields 0x00 give a 16x sampling tick.
// - eight-times field 0xff with four-times 0x00 gives 8x; both 0xff is reserved.
// - four-times field 0xff with eight-times 0x00 gives 4x.
// - in 8x mode an odd fraction gives a bit jitter of plus or minus half a prescaled clock.
// - one reference clock feeds all eight channel generators.
// - one bit period lasts 16, 8 or 4 sampling periods per mode.
package baud_pkg;

	// ***********************************************************
	// register map (apb byte addresses)
	// ***********************************************************
	localparam logic [11:0] CH_STRIDE       = 12'h020;
	localparam logic [4:0]  OFF_DIV_LOW     = 5'h00;
	localparam logic [4:0]  OFF_DIV_HIGH    = 5'h04;
	localparam logic [4:0]  OFF_DIV_FRAC    = 5'h08;
	localparam logic [4:0]  OFF_MODEM_CTRL  = 5'h0c;
	localparam logic [4:0]  OFF_EIGHT_SEL   = 5'h10;
	localparam logic [4:0]  OFF_FOUR_SEL    = 5'h14;
	localparam logic [4:0]  OFF_STATUS      = 5'h18;

	// ***********************************************************
	// reset values and fields
	// ***********************************************************
	localparam logic [7:0]  RST_DIV_LOW     = 8'h01;
	localparam logic [7:0]  RST_DIV_HIGH    = 8'h00;
	localparam logic [3:0]  RST_DIV_FRAC    = 4'h0;
	localparam logic [7:0]  RST_MODEM_CTRL  = 8'h00;
	localparam logic [7:0]  RST_SEL         = 8'h00;
	localparam logic [7:0]  SEL_ON          = 8'hff;
	localparam logic [7:0]  SEL_OFF         = 8'h00;
	localparam int          PRESCALE_BIT    = 7;
	localparam logic [1:0]  PRESCALE_DIV4   = 2'h3;
	localparam int          NUM_CHANNELS    = 8;

	typedef enum logic [1:0] {
		MODE_X16  = 2'b00,
		MODE_X8   = 2'b01,
		MODE_X4   = 2'b11,
		MODE_RSVD = 2'b10
	} samp_mode_t;

	// per-channel divisor settings
	typedef struct packed {
		logic [15:0] int_div;
		logic [3:0]  frac;
		logic        prescale4;
	} div_cfg_t;

endpackage

// ==== src/baud_prescaler.sv ====
// prescaler: divide-by-1 or divide-by-4 enable pulse
`timescale 1ns/1ps
module baud_prescaler
	import baud_pkg::*;
(
	input  wire logic pclk,      // reference clock
	input  wire logic presetn,   // async reset, active low
	input  wire logic div4,      // 1: divide by four
	output logic      tick       // prescaled enable, one cycle
);
	logic [1:0] cnt_r;

	// free count; a change of ratio takes effect within four cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 2'h0;
		end else begin
			cnt_r <= cnt_r + 2'h1;
		end
	end

	assign tick = div4 ? (cnt_r == PRESCALE_DIV4) : 1'b1;
endmodule

// ==== src/baud_divider.sv ====
// fractional divider for one channel, 16.4 fixed point
`timescale 1ns/1ps
module baud_divider
	import baud_pkg::*;
(
	input  wire logic     pclk,     // reference clock
	input  wire logic     presetn,  // async reset, active low
	input  wire logic     pre_tick, // prescaled enable
	input  baud_pkg::div_cfg_t cfg, // divisor setting
	input  wire logic [1:0] bit_len_log, // log2 of 16 over ticks per bit
	output logic          samp_tick,// sampling tick, one cycle
	output logic          bit_tick, // bit boundary, one cycle
	output logic [3:0]    phase     // period index within group of 16
);
	import baud_pkg::*;

	logic [15:0] cnt_r;
	logic [3:0]  phase_r;
	logic [3:0]  bitc_r;
	logic        stretch;
	logic [4:0]  rev;
	logic [15:0] target;

	// bit-reversed phase spreads the extra cycles evenly
	assign rev     = {1'b0, phase_r[0], phase_r[1], phase_r[2], phase_r[3]};
	assign stretch = rev < {1'b0, cfg.frac};
	// integer 0 is treated as 1, the least divisor
	assign target  = (cfg.int_div == 16'h0000) ? 16'h0000 :
		cfg.int_div - (stretch ? 16'h0000 : 16'h0001);

	// count prescaled ticks; period is int_div or int_div+1
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 16'h0000;
		end else if (pre_tick) begin
			if (cnt_r >= target) begin
				cnt_r <= 16'h0000;
			end else begin
				cnt_r <= cnt_r + 16'h0001;
			end
		end
	end

	// sampling tick at the end of each period
	assign samp_tick = pre_tick && (cnt_r >= target);

	// phase within the group of sixteen periods
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_r <= 4'h0;
		end else if (samp_tick) begin
			phase_r <= phase_r + 4'h1;
		end
	end

	// bit period of 16, 8 or 4 sampling periods
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bitc_r <= 4'h0;
		end else if (samp_tick) begin
			if (bit_tick) begin
				bitc_r <= 4'h0;
			end else begin
				bitc_r <= bitc_r + 4'h1;
			end
		end
	end

	// in 8x a half group ends mid-spread, so odd fractions jitter
	assign bit_tick = samp_tick &&
		(bitc_r == 4'((5'h10 >> bit_len_log) - 5'h01));
	assign phase    = phase_r;
endmodule

// ==== src/fractional_baud_generator.sv ====
// top: apb registers and eight channel baud generators
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module fractional_baud_generator
	import baud_pkg::*;
#(
	parameter int CHANNELS = baud_pkg::NUM_CHANNELS // channel count
)(
	input  wire logic               pclk,      // shared reference clock
	input  wire logic               presetn,   // async reset, active low
	input  wire logic               psel,      // apb select
	input  wire logic               penable,   // apb access phase
	input  wire logic               pwrite,    // apb write
	input  wire logic [11:0]        paddr,     // apb byte address
	input  wire logic [31:0]        pwdata,    // apb write data
	output logic [31:0]             prdata,    // apb read data
	output logic                    pready,    // apb ready
	output logic                    pslverr,   // apb error
	output logic [CHANNELS-1:0]     samp_tick, // per-channel sampling tick
	output logic [CHANNELS-1:0]     bit_tick   // per-channel bit boundary
);
	import baud_pkg::*;

	// ***********************************************************
	// bus decode
	// ***********************************************************
	logic        acc;
	logic        wr;
	logic [2:0]  ch;
	logic [4:0]  off;
	logic        ch_ok;
	logic        off_ok;

	assign acc    = psel && penable;
	assign wr     = acc && pwrite && ch_ok && off_ok;
	assign ch     = paddr[7:5];
	assign off    = paddr[4:0];
	assign ch_ok  = (paddr[11:8] == 4'h0) && (32'(ch) < 32'(CHANNELS));
	assign off_ok = (off[1:0] == 2'b00) && (off <= OFF_STATUS);
	// zero wait states; unmapped answers with an error
	assign pready  = 1'b1;
	assign pslverr = acc && !(ch_ok && off_ok);

	// ***********************************************************
	// per-channel registers and generators
	// ***********************************************************
	logic [7:0]       div_low_r   [CHANNELS];
	logic [7:0]       div_high_r  [CHANNELS];
	logic [3:0]       div_frac_r  [CHANNELS];
	logic [7:0]       mctrl_r     [CHANNELS];
	logic [7:0]       eight_sel_r [CHANNELS];
	logic [7:0]       four_sel_r  [CHANNELS];
	samp_mode_t       mode        [CHANNELS];
	logic [3:0]       phase       [CHANNELS];
	logic [CHANNELS-1:0] gen_tick;
	logic [CHANNELS-1:0] gen_bit;

	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : g_ch
			logic       pre_tick;
			logic [1:0] bit_len_log;
			div_cfg_t   cfg;
			logic       sel_me;

			assign sel_me = wr && (32'(ch) == g);

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					div_low_r[g]  <= RST_DIV_LOW;
					div_high_r[g] <= RST_DIV_HIGH;
					div_frac_r[g] <= RST_DIV_FRAC;
				end else if (sel_me) begin
					if (off == OFF_DIV_LOW) begin
						div_low_r[g] <= pwdata[7:0];
					end
					if (off == OFF_DIV_HIGH) begin
						div_high_r[g] <= pwdata[7:0];
					end
					if (off == OFF_DIV_FRAC) begin
						div_frac_r[g] <= pwdata[3:0];
					end
				end
			end

			// mode and prescale control
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					mctrl_r[g]     <= RST_MODEM_CTRL;
					eight_sel_r[g] <= RST_SEL;
					four_sel_r[g]  <= RST_SEL;
				end else if (sel_me) begin
					if (off == OFF_MODEM_CTRL) begin
						mctrl_r[g] <= pwdata[7:0];
					end
					if (off == OFF_EIGHT_SEL) begin
						eight_sel_r[g] <= pwdata[7:0];
					end
					if (off == OFF_FOUR_SEL) begin
						four_sel_r[g] <= pwdata[7:0];
					end
				end
			end

			// mode decode
			// any value other than 0xff counts as off
			always_comb begin
				mode[g] = MODE_X16;
				if ((eight_sel_r[g] == SEL_ON) && (four_sel_r[g] == SEL_ON)) begin
					mode[g] = MODE_RSVD;
				end else if (eight_sel_r[g] == SEL_ON) begin
					mode[g] = MODE_X8;
				end else if (four_sel_r[g] == SEL_ON) begin
					mode[g] = MODE_X4;
				end
			end

			// reserved combination behaves as 16x
			always_comb begin
				unique case (mode[g])
					MODE_X8:  bit_len_log = 2'd1;
					MODE_X4:  bit_len_log = 2'd2;
					default:  bit_len_log = 2'd0;
				endcase
			end

			// integer from two bytes, fraction apart
			assign cfg.int_div   = {div_high_r[g], div_low_r[g]};
			assign cfg.frac      = div_frac_r[g];
			assign cfg.prescale4 = mctrl_r[g][PRESCALE_BIT];

			// every channel runs from the shared pclk
			baud_prescaler u_pre (
				.pclk    (pclk),
				.presetn (presetn),
				.div4    (cfg.prescale4),
				.tick    (pre_tick)
			);

			baud_divider u_div (
				.pclk        (pclk),
				.presetn     (presetn),
				.pre_tick    (pre_tick),
				.cfg         (cfg),
				.bit_len_log (bit_len_log),
				.samp_tick   (gen_tick[g]),
				.bit_tick    (gen_bit[g]),
				.phase       (phase[g])
			);
		end
	endgenerate

	// registered tick outputs, one cycle after the divider
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			samp_tick <= '0;
			bit_tick  <= '0;
		end else begin
			samp_tick <= gen_tick;
			bit_tick  <= gen_bit;
		end
	end

	// ***********************************************************
	// read mux
	// ***********************************************************
	always_comb begin
		prdata = 32'h0000_0000;
		if (acc && !pwrite && ch_ok && off_ok) begin
			unique case (off)
				OFF_DIV_LOW:    prdata[7:0] = div_low_r[ch];
				OFF_DIV_HIGH:   prdata[7:0] = div_high_r[ch];
				OFF_DIV_FRAC:   prdata[3:0] = div_frac_r[ch];
				OFF_MODEM_CTRL: prdata[7:0] = mctrl_r[ch];
				OFF_EIGHT_SEL:  prdata[7:0] = eight_sel_r[ch];
				OFF_FOUR_SEL:   prdata[7:0] = four_sel_r[ch];
				OFF_STATUS:     prdata[5:0] = {mode[ch], phase[ch]};
				default:        prdata = 32'h0000_0000;
			endcase
		end
	end
endmodule

// ==== test/baud_gen_asserts.sv ====
// checker: bus and tick assertions of the baud generator
`timescale 1ns/1ps
module baud_gen_asserts
	import baud_pkg::*;
#(
	parameter int CHANNELS = 8 // channel count
)(
	input wire logic                pclk,      // clock
	input wire logic                presetn,   // reset, active low
	input wire logic                psel,      // select
	input wire logic                penable,   // access
	input wire logic                pwrite,    // write
	input wire logic [11:0]         paddr,     // address
	input wire logic [31:0]         pwdata,    // write data
	input wire logic [31:0]         prdata,    // read data
	input wire logic                pready,    // ready
	input wire logic                pslverr,   // error
	input wire logic [CHANNELS-1:0] samp_tick, // sampling ticks
	input wire logic [CHANNELS-1:0] bit_tick   // bit ticks
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// access and read phases of a transfer
	sequence s_acc;
		psel && penable;
	endsequence
	sequence s_rd;
		psel && penable && !pwrite;
	endsequence
	a_ready_zero_wait: assert property (s_acc |-> pready)
		else $error("ready low in access");
	a_idle_rdata_zero: assert property (!(psel && penable) |-> prdata == 0)
		else $error("read data outside access");
	a_idle_no_err: assert property (!(psel && penable) |-> !pslverr)
		else $error("error outside access");
	a_bad_page_err: assert property (
		(s_acc and (paddr[11:8] != 4'h0)) |-> pslverr)
		else $error("unmapped page accepted");
	a_good_addr_ok: assert property ((s_acc and (paddr[11:8] == 4'h0
		&& paddr[4:0] == OFF_DIV_LOW && paddr[7:5] < CHANNELS)) |-> !pslverr)
		else $error("mapped address refused");
	a_read_byte_only: assert property (s_rd |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_frac_four_bits: assert property (
		(s_rd and (paddr[4:0] == OFF_DIV_FRAC)) |-> prdata[7:4] == 4'h0)
		else $error("fraction above four bits");
	a_bit_on_samp: assert property (bit_tick[0] |-> samp_tick[0])
		else $error("bit tick without sample tick");
endmodule

bind fractional_baud_generator baud_gen_asserts #(.CHANNELS(CHANNELS)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .samp_tick(samp_tick),
	.bit_tick(bit_tick));

// ==== test/tick_sink.sv ====
// partner: channel sampling logic counting samples in each bit
`timescale 1ns/1ps
module tick_sink (
	input wire logic  pclk,      // clock
	input wire logic  presetn,   // reset, active low
	input wire logic  samp_tick, // sampling tick
	input wire logic  bit_tick,  // bit boundary
	output logic [7:0] per_bit   // samples in the last bit
);
	logic [7:0] cnt_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 8'h0;
			per_bit <= 8'h0;
		end else if (bit_tick) begin
			per_bit <= cnt_r + 8'h1;
			cnt_r <= 8'h0;
		end else if (samp_tick) begin
			cnt_r <= cnt_r + 8'h1;
		end
	end
endmodule

// ==== test/fractional_baud_generator_tb_top.sv ====
// testbench: register, rate and mode scenarios of the baud generator
`timescale 1ns/1ps
module fractional_baud_generator_tb_top;
	import baud_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0]  samp_tick, bit_tick, per_bit;
	int          bad_count, compares, c;
	int          cyc = 0;
	logic [15:0] tn [4] = '{16'h3, 16'h3, 16'h2, 16'h1};
	logic [3:0]  tf [4] = '{4'h0, 4'h4, 4'h0, 4'hf};
	logic        tp [4] = '{1'b0, 1'b0, 1'b1, 1'b0};

	fractional_baud_generator #(.CHANNELS(8)) u_dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .samp_tick(samp_tick), .bit_tick(bit_tick));
	tick_sink u_sink (.pclk(pclk), .presetn(presetn),
		.samp_tick(samp_tick[0]), .bit_tick(bit_tick[0]), .per_bit(per_bit));

	// 40 ns clock
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// hang guard, far above the planned run
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			complete_run();
		end
	end

	task complete_run();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task check(input string n, input logic [31:0] s, input logic [31:0] x);
		compares++;
		if (s !== x) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, x, s);
		end
	endtask
	// one apb transfer; holds the request until ready is sampled
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function logic [11:0] ad(input int ch, input logic [4:0] off);
		return {4'h0, 3'(ch), off};
	endfunction
	task set_div(input logic [15:0] n, input logic [3:0] f, input logic p);
		apb(1, ad(0, OFF_DIV_HIGH), {24'h0, 8'(n >> 8)});
		apb(1, ad(0, OFF_DIV_LOW), {24'h0, 8'(n & 16'h00ff)});
		apb(1, ad(0, OFF_DIV_FRAC), {28'h0, f});
		apb(1, ad(0, OFF_MODEM_CTRL), {24'h0, p, 7'h0});
	endtask
	// cycles spent over k sampling periods, starting on a tick
	task span(input int k);
		int n;
		n = 0;
		c = 0;
		do @(posedge pclk); while (samp_tick[0] !== 1'b1);
		while (n < k) begin
			@(posedge pclk);
			c++;
			if (samp_tick[0] === 1'b1)
				n++;
		end
	endtask
	task t_reset();
		@(posedge pclk);
		check("ticks", {24'h0, samp_tick}, 32'hff);
		for (int ch = 0; ch < 8; ch++) begin
			apb(0, ad(ch, OFF_DIV_LOW), 0);
			check("low", rd, 32'h1);
			apb(0, ad(ch, OFF_DIV_HIGH), 0);
			check("high", rd, 32'h0);
			apb(0, ad(ch, OFF_DIV_FRAC), 0);
			check("frac", rd, 32'h0);
		end
	endtask
	task t_regs();
		apb(1, ad(0, OFF_DIV_FRAC), 32'hff);
		apb(0, ad(0, OFF_DIV_FRAC), 0);
		check("frac", rd, 32'hf);
		set_div(16'h1234, 4'h0, 1'b0);
		apb(0, ad(0, OFF_DIV_HIGH), 0);
		check("high", rd, 32'h12);
		apb(0, ad(0, OFF_DIV_LOW), 0);
		check("low", rd, 32'h34);
	endtask
	task t_err();
		apb(0, 12'h100, 0);
		check("page", {31'h0, err}, 32'h1);
		check("pdata", rd, 32'h0);
		apb(1, ad(0, 5'h1c), 32'h55);
		check("off", {31'h0, err}, 32'h1);
		apb(0, ad(0, 5'h02), 0);
		check("align", {31'h0, err}, 32'h1);
	endtask
	// 16 periods span 16n+f input cycles, four times that with prescale
	task t_rate();
		for (int i = 0; i < 4; i++) begin
			set_div(tn[i], tf[i], tp[i]);
			span(2);
			span(16);
			check("span", c, (16 * tn[i] + tf[i]) * (tp[i] ? 4 : 1));
		end
	endtask
	task t_modes();
		logic [7:0] s8 [5] = '{8'h00, 8'hff, 8'h00, 8'hff, 8'hfe};
		logic [7:0] s4 [5] = '{8'h00, 8'h00, 8'hff, 8'hff, 8'h00};
		logic [7:0] pb [5] = '{8'd16, 8'd8, 8'd4, 8'd16, 8'd16};
		samp_mode_t md [5] = '{MODE_X16, MODE_X8, MODE_X4, MODE_RSVD, MODE_X16};
		int k;
		set_div(16'h1, 4'h0, 1'b0);
		for (int i = 0; i < 5; i++) begin
			apb(1, ad(0, OFF_EIGHT_SEL), {24'h0, s8[i]});
			apb(1, ad(0, OFF_FOUR_SEL), {24'h0, s4[i]});
			apb(0, ad(0, OFF_STATUS), 0);
			check("mode", {30'h0, rd[5:4]}, {30'h0, md[i]});
			k = 0;
			while (k < 3) begin
				@(posedge pclk);
				if (bit_tick[0] === 1'b1)
					k++;
			end
			check("per bit", {24'h0, per_bit}, {24'h0, pb[i]});
		end
	endtask

	// reset for 16 cycles, then the scenarios
	initial begin
		{psel, penable, pwrite, presetn} = 4'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		bad_count = 0;
		compares = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		t_reset();
		t_regs();
		t_err();
		t_rate();
		t_modes();
		complete_run();
	end
endmodule
